// ### moe_pkg.sv
// Constants, state enumeration and state record of the micro-op executor.
`default_nettype none
package moe_pkg;
   // =====================================================================
   // Register map (byte addresses on the Avalon-MM slave)
   localparam logic [7:0] ADDR_INSTR = 8'h00; // Write starts one microinstruction
   localparam logic [7:0] ADDR_X = 8'h04;
   localparam logic [7:0] ADDR_Y = 8'h08;
   localparam logic [7:0] ADDR_T = 8'h0C;
   localparam logic [7:0] ADDR_L = 8'h10;
   localparam logic [7:0] ADDR_FA = 8'h14;
   localparam logic [7:0] ADDR_FL = 8'h18;
   localparam logic [7:0] ADDR_FU = 8'h1C;
   localparam logic [7:0] ADDR_CP = 8'h20;
   localparam logic [7:0] ADDR_CPL = 8'h24;
   localparam logic [7:0] ADDR_MADDR = 8'h28;
   localparam logic [7:0] ADDR_CAPT = 8'h2C;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_ARMED = 1;
   localparam int ST_FL_UFLOW = 2;
   localparam int ST_ILLEGAL = 3;
   // =====================================================================
   // Opcodes
   localparam logic [3:0] OPC_DGRP = 4'h0;
   localparam logic [3:0] OPC_EXT = 4'hB;
   localparam logic [3:0] OPC_BRF = 4'hC;
   localparam logic [3:0] OPC_BRR = 4'hD;
   localparam logic [3:0] OPC_CALF = 4'hE;
   localparam logic [3:0] OPC_CALR = 4'hF;
   localparam logic [3:0] DOP_SWAP = 4'h2;
   localparam logic [3:0] DOP_CLR = 4'h3;
   localparam logic [3:0] DOP_SR1 = 4'h4;
   localparam logic [3:0] DOP_SR2 = 4'h5;
   localparam logic [3:0] DOP_CNT = 4'h6;
   localparam logic [3:0] DOP_XCH = 4'h7;
   localparam logic [3:0] DOP_SPREL = 4'h8;
   localparam logic [3:0] DOP_MON = 4'h9;
   localparam logic [3:0] DOP_NANO = 4'hA;
   localparam logic [15:0] RET_WORD = 16'h1BA4; // Move top of stack to address
   // =====================================================================
   // Widths, counts and reset values
   localparam logic [23:0] STEP = 24'h000010; // One microinstruction in bits
   localparam logic [5:0] WMAX = 6'h18; // Register width, 24
   localparam logic [5:0] DMAX = 6'h30; // Concatenated width, 48
   localparam int CW_BITS = 114;
   localparam int W0_BITS = 18;
   localparam int NW_BITS = 24;
   localparam logic [2:0] SWAP_LAST = 3'h3; // Swap runs four nanos
   localparam logic [2:0] CNT2_LAST = 3'h1; // Two-nano count variants
   localparam logic [23:0] REG_RST = 24'h000000;
   // =====================================================================
   typedef enum logic [1:0] {MOE_IDLE, MOE_EXEC, MOE_SNAP} moe_state_type;
   typedef struct packed {
      moe_state_type state;
      logic [23:0] x, y, t, l, fa, fl, maddr, capt, mwdata, maddr_o;
      logic [3:0] fu;
      logic [7:0] cp, mon_var;
      logic [4:0] current_length_value, mwidth;
      logic [15:0][23:0] stk;
      logic [3:0] sp;
      logic [15:0][47:0] pad;
      logic [CW_BITS-1:0] ctrl;
      logic [15:0] instr;
      logic [2:0] seq, nsel;
      logic [3:0] stop;
      logic armed, abort, fl_uflow, illegal, rd_done, mreq;
      logic [31:0] rdata;
   } moe_regs_type;
endpackage
`default_nettype wire

// ### moe_executor.sv
// Micro-op executor: one group of microinstructions with an Avalon-MM slave.
//
// Chosen here: register access over Avalon-MM and the register addresses.
`default_nettype none
module moe_executor import moe_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic mem_req_out,
   output logic [23:0] mem_addr_out,
   output logic [4:0] mem_width_out,
   output logic [23:0] mem_wdata_out,
   input wire logic [23:0] mem_rdata_in,
   input wire logic mem_ack_in,
   output logic mon_gen_out,
   output logic [7:0] mon_variant_out,
   output logic [3:0] mon_sel_out,
   output logic busy_out
);
   // =====================================================================
   // Helpers
   // Rotate or shift 24 bits; count 0..24
   function automatic logic [23:0] sr24(input logic [23:0] v, input logic rot,
      input logic right, input logic [5:0] k);
      logic [23:0] a, b;
      a = right ? (v >> k) : (v << k);
      b = right ? (v << (WMAX - k)) : (v >> (WMAX - k));
      return rot ? (a | b) : a;
   endfunction
   // Same on the 48-bit concatenation
   function automatic logic [47:0] sr48(input logic [47:0] v, input logic rot,
      input logic right, input logic [5:0] k);
      logic [47:0] a, b;
      a = right ? (v >> k) : (v << k);
      b = right ? (v << (DMAX - k)) : (v >> (DMAX - k));
      return rot ? (a | b) : a;
   endfunction
   // Low-bit mask of a width; 24 or more keeps everything
   function automatic logic [23:0] lowmask(input logic [5:0] w);
      return (w >= WMAX) ? 24'hFFFFFF : 24'((25'h1 << w) - 25'h1);
   endfunction
   // Cap a count at a limit
   function automatic logic [5:0] cap(input logic [5:0] k, input logic [5:0] lim);
      return (k > lim) ? lim : k;
   endfunction
   // Byte-lane merge for partial writes
   function automatic logic [23:0] bmerge(input logic [23:0] old, input logic [31:0] d,
      input logic [3:0] be);
      logic [23:0] v;
      v = old;
      for (int i = 0; i < 3; i++) begin
         if (be[i]) begin
            v[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return v;
   endfunction

   // =====================================================================
   // State and decode
   moe_regs_type r, n; // Whole state and its next value
   logic [3:0] op, dop; // Main and second-group opcode
   logic is_d, is_swap, is_cnt, is_ret, is_ext, is_br, is_call, is_clr, is_mon;
   logic [2:0] last; // Final nano index of the current op
   logic snap_hit, eff, restricted;
   logic [23:0] nxt, ext_val, br_tgt;
   logic [5:0] swap_w, cnt_amt;
   logic [23:0] gpr_sel;

   assign op = r.instr[15:12];
   assign dop = r.instr[11:8];
   assign is_d = (op == OPC_DGRP);
   assign is_ret = (r.instr == RET_WORD);
   assign is_ext = (op == OPC_EXT);
   assign is_br = (op == OPC_BRF) || (op == OPC_BRR);
   assign is_call = (op == OPC_CALF) || (op == OPC_CALR);
   assign is_swap = is_d && (dop == DOP_SWAP);
   assign is_clr = is_d && (dop == DOP_CLR);
   assign is_cnt = is_d && (dop == DOP_CNT);
   assign is_mon = is_d && (dop == DOP_MON);
   // Memory is changed by the swap, so abort must not apply there
   assign restricted = is_swap;
   assign last = is_swap ? SWAP_LAST :
      (is_cnt && (r.instr[7:5] inside {3'h3, 3'h4, 3'h7})) ? CNT2_LAST : 3'h0;
   // Stop at the requested nano; never matches past the op's last nano
   assign snap_hit = (r.state == MOE_EXEC) && r.armed && (r.seq == {1'b0, r.stop[1:0]})
      && (r.stop[3:2] == 2'b00) && !r.mreq;
   assign eff = (r.state == MOE_EXEC) && !snap_hit && (r.seq == last)
      && (!is_swap || (r.mreq && mem_ack_in));
   assign nxt = r.maddr + STEP;
   // Wrap-around rotation of T, then keep the extract count low bits
   assign ext_val = sr24(r.t, 1'b1, 1'b0, (r.instr[11:7] >= 5'h18) ?
      6'(r.instr[11:7] - 5'h18) : {1'b0, r.instr[11:7]})
      & lowmask({1'b0, r.instr[4:0]});
   // Displacement counts microinstructions, hence the factor 16
   assign br_tgt = r.instr[12] ? (nxt - {8'h00, r.instr[11:0], 4'h0})
      : (nxt + {8'h00, r.instr[11:0], 4'h0});
   // Zero width falls back to the current length value
   assign swap_w = cap((r.instr[4:0] == 5'h00) ? {1'b0, r.current_length_value} : {1'b0, r.instr[4:0]},
      WMAX);
   assign cnt_amt = cap((r.instr[4:0] == 5'h00) ? {1'b0, r.current_length_value} : {1'b0, r.instr[4:0]},
      WMAX);
   always_comb begin
      unique case (r.instr[7:6])
         2'b00: gpr_sel = r.x;
         2'b01: gpr_sel = r.y;
         2'b10: gpr_sel = r.t;
         default: gpr_sel = r.l;
      endcase
   end

   // =====================================================================
   // Next-state logic
   always_comb begin
      logic [23:0] rv, v24;
      logic [47:0] v48;
      logic [6:0] cidx;
      logic [4:0] code;
      rv = 24'h000000;
      v24 = 24'h000000;
      v48 = 48'h0;
      code = is_d ? 5'(5'h10 + {1'b0, dop}) : {1'b0, op};
      cidx = 7'(code * 3 + r.seq);
      n = r;
      n.rd_done = 1'b0;
      // Register reads answer one cycle after the request
      if (avs_read_in && !r.rd_done) begin
         n.rd_done = 1'b1;
         unique case (avs_address_in)
            ADDR_X: rv = r.x;
            ADDR_Y: rv = r.y;
            ADDR_T: rv = r.t;
            ADDR_L: rv = r.l;
            ADDR_FA: rv = r.fa;
            ADDR_FL: rv = r.fl;
            ADDR_FU: rv = {20'h0, r.fu};
            ADDR_CP: rv = {16'h0, r.cp};
            ADDR_CPL: rv = {19'h0, r.current_length_value};
            ADDR_MADDR: rv = r.maddr;
            ADDR_CAPT: rv = r.capt;
            ADDR_INSTR: rv = {8'h00, r.instr};
            ADDR_STATUS: rv = {20'h0, r.illegal, r.fl_uflow, r.armed, r.state != MOE_IDLE};
            default: rv = 24'h000000;
         endcase
         n.rdata = {8'h00, rv};
      end
      // Writes are taken only while idle; the bus stalls otherwise
      if (avs_write_in && r.state == MOE_IDLE) begin
         unique case (avs_address_in)
            ADDR_X: n.x = bmerge(r.x, avs_writedata_in, avs_byteenable_in);
            ADDR_Y: n.y = bmerge(r.y, avs_writedata_in, avs_byteenable_in);
            ADDR_T: n.t = bmerge(r.t, avs_writedata_in, avs_byteenable_in);
            ADDR_L: n.l = bmerge(r.l, avs_writedata_in, avs_byteenable_in);
            ADDR_FA: n.fa = bmerge(r.fa, avs_writedata_in, avs_byteenable_in);
            ADDR_FL: n.fl = bmerge(r.fl, avs_writedata_in, avs_byteenable_in);
            ADDR_FU: n.fu = avs_byteenable_in[0] ? avs_writedata_in[3:0] : r.fu;
            ADDR_CP: n.cp = avs_byteenable_in[0] ? avs_writedata_in[7:0] : r.cp;
            ADDR_CPL: n.current_length_value = avs_byteenable_in[0] ? avs_writedata_in[4:0] : r.current_length_value;
            ADDR_MADDR: n.maddr = bmerge(r.maddr, avs_writedata_in, avs_byteenable_in);
            ADDR_INSTR: begin
               // Fresh decode: control word starts empty
               n.instr = avs_writedata_in[15:0];
               n.state = MOE_EXEC;
               n.seq = 3'h0;
               n.ctrl = '0;
               n.illegal = 1'b0;
            end
            ADDR_STATUS: n.fl_uflow = r.fl_uflow & ~avs_writedata_in[ST_FL_UFLOW];
            default: n.state = r.state;
         endcase
      end
      unique case (r.state)
         MOE_IDLE: begin
            n.mreq = 1'b0;
         end
         MOE_EXEC: begin
            n.ctrl[cidx] = 1'b1;
            if (snap_hit) begin
               // Suspend and take the selected nano word
               n.state = MOE_SNAP;
               n.armed = 1'b0;
               unique case (r.nsel)
                  // Capture includes the nano just reached
                  3'h0: n.capt = {6'h00, n.ctrl[W0_BITS-1:0]};
                  3'h1: n.capt = n.ctrl[W0_BITS +: NW_BITS];
                  3'h2: n.capt = n.ctrl[W0_BITS+NW_BITS +: NW_BITS];
                  3'h3: n.capt = n.ctrl[W0_BITS+2*NW_BITS +: NW_BITS];
                  3'h4: n.capt = n.ctrl[W0_BITS+3*NW_BITS +: NW_BITS];
                  default: n.capt = 24'h000000;
               endcase
            end else if (r.seq != last) begin
               n.seq = 3'(r.seq + 3'h1);
            end else if (is_swap && !r.mreq) begin
               // Issue one exchange with memory
               n.mreq = 1'b1;
               n.mwidth = swap_w[4:0];
               n.maddr_o = r.instr[5] ? (r.fa - {18'h0, swap_w}) : r.fa;
               n.mwdata = gpr_sel & lowmask(swap_w);
            end else if (eff) begin
               n.state = MOE_IDLE;
               n.mreq = 1'b0;
               n.maddr = nxt;
               if (is_ret) begin
                  // Return pops the stack
                  n.maddr = r.stk[4'(r.sp - 4'h1)];
                  n.sp = 4'(r.sp - 4'h1);
               end else if (is_ext) begin
                  unique case (r.instr[6:5])
                     2'b00: n.x = ext_val;
                     2'b01: n.y = ext_val;
                     2'b10: n.t = ext_val;
                     default: n.l = ext_val;
                  endcase
               end else if (is_br) begin
                  n.maddr = br_tgt;
               end else if (is_call) begin
                  n.stk[r.sp] = nxt << 4;
                  n.sp = 4'(r.sp + 4'h1);
                  n.maddr = r.instr[12] ? (nxt - {12'h0, r.instr[11:0]})
                     : (nxt + {12'h0, r.instr[11:0]});
               end else if (is_d) begin
                  unique case (dop)
                     DOP_SWAP: begin
                        v24 = mem_rdata_in & lowmask(swap_w);
                        unique case (r.instr[7:6])
                           2'b00: n.x = v24;
                           2'b01: n.y = v24;
                           2'b10: n.t = v24;
                           default: n.l = v24;
                        endcase
                     end
                     DOP_CLR: begin
                        if (r.instr[6]) n.l = REG_RST;
                        if (r.instr[5]) n.t = REG_RST;
                        if (r.instr[4]) n.y = REG_RST;
                        if (r.instr[3]) n.x = REG_RST;
                        if (r.instr[2]) n.fa = REG_RST;
                        if (r.instr[1]) n.fu = 4'h0;
                        if (r.instr[0]) n.cp = 8'h00;
                     end
                     DOP_SR1: begin
                        v24 = sr24(r.instr[7] ? r.y : r.x, r.instr[6], r.instr[5],
                           cap({1'b0, r.instr[4:0]}, WMAX));
                        if (r.instr[7]) n.y = v24;
                        else n.x = v24;
                     end
                     DOP_SR2: begin
                        v48 = sr48({r.x, r.y}, r.instr[7], r.instr[6],
                           cap(r.instr[5:0], DMAX));
                        n.x = v48[47:24];
                        n.y = v48[23:0];
                     end
                     DOP_CNT: begin
                        unique case (r.instr[7:5])
                           3'h0: n.fa = r.fa + {18'h0, cnt_amt};
                           3'h1: n.fa = r.fa - {18'h0, cnt_amt};
                           3'h2: n.fl = r.fl + {18'h0, cnt_amt};
                           3'h4: n.fa = r.fa + {18'h0, cnt_amt};
                           3'h5: begin
                              n.fa = r.fa - {18'h0, cnt_amt};
                              n.fl = r.fl + {18'h0, cnt_amt};
                           end
                           3'h6: n.illegal = 1'b1; // Both up is not allowed
                           default: n.fa = (r.instr[7:5] == 3'h7) ?
                              r.fa - {18'h0, cnt_amt} : r.fa;
                        endcase
                        // Length counts down in variants 3, 4 and 7
                        if (r.instr[7:5] inside {3'h3, 3'h4, 3'h7}) begin
                           if (r.fl < {18'h0, cnt_amt}) begin
                              n.fl = REG_RST;
                              n.fl_uflow = 1'b1;
                           end else begin
                              n.fl = r.fl - {18'h0, cnt_amt};
                           end
                        end
                     end
                     DOP_XCH: begin
                        // Old value is read before the write, so equal fields swap
                        {n.fa, n.fl} = r.pad[r.instr[3:0]];
                        n.pad[r.instr[7:4]] = {r.fa, r.fl};
                     end
                     DOP_SPREL: begin
                        // No limiting: sum wraps at 24 bits
                        n.fa = r.instr[4] ? (r.fa - r.pad[r.instr[3:0]][47:24])
                           : (r.fa + r.pad[r.instr[3:0]][47:24]);
                     end
                     DOP_NANO: begin
                        n.armed = 1'b1;
                        n.abort = r.instr[7];
                        n.stop = r.instr[6:3];
                        n.nsel = r.instr[2:0];
                     end
                     default: n.illegal = (dop != DOP_MON);
                  endcase
               end
            end
         end
         MOE_SNAP: begin
            if (r.abort && !restricted) begin
               // Abort: drop the microinstruction and move on
               n.ctrl = '0;
               n.state = MOE_IDLE;
               n.maddr = nxt;
            end else begin
               n.state = MOE_EXEC;
            end
         end
         default: n.state = MOE_IDLE;
      endcase
   end

   // =====================================================================
   // State register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   // =====================================================================
   // Outputs
   assign avs_readdata_out = r.rdata;
   // Reads wait one cycle; writes wait while an op runs
   assign avs_waitrequest_out = (avs_read_in && !r.rd_done)
      || (avs_write_in && r.state != MOE_IDLE);
   assign mem_req_out = r.mreq;
   assign mem_addr_out = r.maddr_o;
   assign mem_width_out = r.mwidth;
   assign mem_wdata_out = r.mwdata;
   assign busy_out = (r.state != MOE_IDLE);
   assign mon_gen_out = (r.state == MOE_EXEC) && is_mon;
   assign mon_variant_out = mon_gen_out ? r.instr[7:0] : 8'h00;
   // Select pins qualified by execution in place of a gated clock
   assign mon_sel_out = mon_gen_out ? (4'h1 << r.instr[1:0]) : 4'h0;

   // =====================================================================
   // Checks
   chk_ext_dest_y: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && is_ext && r.instr[6:5] == 2'b01 |=> r.y == $past(ext_val))
      else $error("extract result wrong");
   chk_ext_t_kept: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && is_ext && r.instr[6:5] != 2'b10 |=> $stable(r.t))
      else $error("extract changed T");
   chk_branch_target: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && op == OPC_BRF |=> r.maddr == $past(r.maddr) + 24'h10
         + {8'h00, $past(r.instr[11:0]), 4'h0})
      else $error("branch target wrong");
   chk_call_push: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && is_call |=> r.sp == $past(r.sp) + 4'h1
         && r.stk[$past(r.sp)] == (($past(r.maddr) + 24'h10) << 4))
      else $error("call push wrong");
   chk_return_pop: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && is_ret |=> r.maddr == $past(r.stk[4'(r.sp - 4'h1)]))
      else $error("return address wrong");
   chk_clear_x: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && is_clr && r.instr[3] |=> r.x == 24'h0 && $stable(r.fl))
      else $error("clear failed");
   chk_fl_uflow: assert property (@(posedge clk_in) disable iff (rst_in)
      eff && is_cnt && r.instr[7:5] == 3'h3 && r.fl < {18'h0, cnt_amt}
         |=> r.fl == 24'h0 && r.fl_uflow)
      else $error("length underflow not caught");
   chk_monitor_pins: assert property (@(posedge clk_in) disable iff (rst_in)
      mon_gen_out |-> $onehot(mon_sel_out) && mon_variant_out == r.instr[7:0])
      else $error("monitor outputs wrong");
   chk_snap_abort: assert property (@(posedge clk_in) disable iff (rst_in)
      r.state == MOE_SNAP && r.abort && !restricted
         |=> r.state == MOE_IDLE && r.ctrl == '0)
      else $error("abort did not clear");
   chk_swap_noabort: assert property (@(posedge clk_in) disable iff (rst_in)
      r.state == MOE_SNAP && is_swap |=> r.state == MOE_EXEC ##[1:8] r.mreq)
      else $error("swap aborted");
   cov_extract: cover property (@(posedge clk_in) eff && is_ext);
   cov_swap: cover property (@(posedge clk_in) eff && is_swap);
   cov_snap: cover property (@(posedge clk_in) r.state == MOE_SNAP ##1 r.state == MOE_IDLE);
   cov_call_ret: cover property (@(posedge clk_in) eff && is_call ##[1:50] eff && is_ret);
endmodule
`default_nettype wire

// ### moe_mem_model.sv
// Memory partner model answering swap requests.
`default_nettype none
module moe_mem_model (
   input wire logic clk_in,
   input wire logic req_in,
   input wire logic [23:0] addr_in,
   input wire logic [23:0] wdata_in,
   input wire logic [4:0] width_in,
   input wire logic [3:0] lat_in,
   output logic ack_out,
   output logic [23:0] rdata_out,
   output logic [23:0] addr_out,
   output logic [23:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt = 4'h0; // Cycles waited
   initial ack_out = 1'h0;
   // Answer after lat_in cycles; data toggles outside the answer cycle
   always @(posedge clk_in) begin
      ack_out <= 1'h0;
      rdata_out <= ~rdata_out;
      if (req_in && !ack_out) begin
         cnt <= cnt + 4'h1;
         if (cnt >= lat_in) begin
            ack_out <= 1'h1;
            rdata_out <= 24'hC3A5F0 & ~(24'hFFFFFF << width_in);
            addr_out <= addr_in;
            wdata_out <= wdata_in;
            cnt <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ### moe_executor_tb.sv
// Self-checking bench for the micro-op executor.
`default_nettype none
module moe_executor_tb import moe_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'h0, rst_in = 1'h1, rd = 1'h0, wr = 1'h0, ws, wq, ack, req, gen, busy;
   logic [7:0] addr = 8'h00, var8;
   logic [31:0] wd = 32'h0, rdat, rs, m;
   logic [23:0] mrd, ma, mw, ga, gd;
   logic [4:0] wid;
   logic [3:0] sel;
   int n_errors = 0, n_tests = 0;
   always #5 clk_in = ~clk_in;
   // Bus outputs are settled by the falling edge
   always @(negedge clk_in) begin
      ws = wq;
      rs = rdat;
   end
   moe_executor uut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .mem_req_out(req),
      .mem_addr_out(ma), .mem_width_out(wid), .mem_wdata_out(mw), .mem_rdata_in(mrd),
      .mem_ack_in(ack), .mon_gen_out(gen), .mon_variant_out(var8), .mon_sel_out(sel),
      .busy_out(busy));
   moe_mem_model mem (.clk_in(clk_in), .req_in(req), .addr_in(ma), .wdata_in(mw),
      .width_in(wid), .lat_in(4'h3), .ack_out(ack), .rdata_out(mrd), .addr_out(ga),
      .wdata_out(gd));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One transfer, held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk_in); while (ws);
      wr <= 1'h0;
      rd <= 1'h0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chk(rs, e);
   endtask
   task automatic summarize();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #30000;
      n_errors++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'h0;
      xfer(1'h1, ADDR_T, 32'h0B1800);
      xfer(1'h1, ADDR_INSTR, 32'hB5A9);
      rc(ADDR_Y, 32'h58);
      rc(ADDR_T, 32'h0B1800);
      xfer(1'h1, ADDR_X, 32'h123456);
      xfer(1'h1, ADDR_INSTR, 32'h0308);
      rc(ADDR_X, 32'h0);
      rc(ADDR_Y, 32'h58);
      xfer(1'h1, ADDR_X, 32'h1);
      xfer(1'h1, ADDR_INSTR, 32'h0404);
      rc(ADDR_X, 32'h10);
      xfer(1'h1, ADDR_Y, 32'h800000);
      xfer(1'h1, ADDR_INSTR, 32'h0501);
      rc(ADDR_X, 32'h21);
      rc(ADDR_Y, 32'h0);
      xfer(1'h1, ADDR_FL, 32'h5);
      xfer(1'h1, ADDR_FA, 32'h40);
      xfer(1'h1, ADDR_INSTR, 32'h066A);
      xfer(1'h1, ADDR_CAPT, 32'h0);
      rc(ADDR_FL, 32'h0);
      rc(ADDR_STATUS, 32'h4);
      xfer(1'h1, ADDR_INSTR, 32'h061E);
      rc(ADDR_FA, 32'h58);
      xfer(1'h1, ADDR_CPL, 32'hC);
      xfer(1'h1, ADDR_FA, 32'h40);
      xfer(1'h1, ADDR_Y, 32'hABC123);
      xfer(1'h1, ADDR_INSTR, 32'h0260);
      xfer(1'h1, ADDR_CAPT, 32'h0);
      rc(ADDR_Y, 32'h5F0);
      chk({8'h00, ga}, 32'h34);
      chk({8'h00, gd}, 32'h123);
      chk({27'h0, wid}, 32'hC);
      xfer(1'h1, ADDR_INSTR, 32'h0700);
      rc(ADDR_FA, 32'h0);
      xfer(1'h1, ADDR_INSTR, 32'h0800);
      rc(ADDR_FA, 32'h40);
      // Snapshot with abort: the clear is dropped, its nano word captured
      xfer(1'h1, ADDR_X, 32'h77);
      xfer(1'h1, ADDR_INSTR, 32'h0A82);
      xfer(1'h1, ADDR_INSTR, 32'h0308);
      xfer(1'h1, ADDR_CAPT, 32'h0);
      rc(ADDR_CAPT, 32'h8000);
      rc(ADDR_X, 32'h77);
      // Snapshot with continue: the clear still lands
      xfer(1'h1, ADDR_INSTR, 32'h0A02);
      xfer(1'h1, ADDR_INSTR, 32'h0308);
      xfer(1'h1, ADDR_CAPT, 32'h0);
      rc(ADDR_X, 32'h0);
      // Abort requested on a swap is ignored
      xfer(1'h1, ADDR_Y, 32'h111);
      xfer(1'h1, ADDR_INSTR, 32'h0A80);
      xfer(1'h1, ADDR_INSTR, 32'h0260);
      xfer(1'h1, ADDR_CAPT, 32'h0);
      rc(ADDR_Y, 32'h5F0);
      chk({8'h00, gd}, 32'h111);
      xfer(1'h1, ADDR_INSTR, 32'h09A6);
      #1;
      chk({gen, sel, var8}, {1'h1, 4'h4, 8'hA6});
      chk({31'h0, busy}, 32'h1);
      @(posedge clk_in);
      #1;
      chk({gen, sel, var8}, 32'h0);
      chk({31'h0, busy}, 32'h0);
      xfer(1'h0, ADDR_MADDR, 32'h0);
      m = rs;
      xfer(1'h1, ADDR_INSTR, 32'hC002);
      rc(ADDR_MADDR, m + 32'h30);
      xfer(1'h1, ADDR_INSTR, 32'hE003);
      rc(ADDR_MADDR, m + 32'h43);
      m = ((m + 32'h40) << 4) & 32'hFFFFFF;
      xfer(1'h1, ADDR_INSTR, 32'h1BA4);
      rc(ADDR_MADDR, m);
      xfer(1'h1, ADDR_INSTR, 32'hD001);
      rc(ADDR_MADDR, m);
      rc(8'h3C, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
